//--- rtl/sram_port_pkg.sv
// Shared types and constants for the burst SRAM port
package sram_port_pkg;
    localparam int ADDR_W      = 10;
    localparam int LANES       = 4;
    localparam int LANE_W      = 9;
    localparam int WORD_W      = LANES * LANE_W;
    localparam int BURST_W     = 2;
    localparam int DATA_LSB    = 0;
    localparam int PARITY_LSB  = 8;
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic       MODE_LINEAR = 1'b0;
    localparam int PIPE_CYCLES = 1;
    localparam int BUF_DEPTH   = 2;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_read  = 2'b01,
        st_write = 2'b11,
        st_sleep = 2'b10
    } port_state_t;

    // Strobes and selects as seen on one clock edge
    typedef struct packed {
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic select_first_n;
        logic select_second;
        logic select_third_n;
    } ctrl_pins_t;

    // Write controls as seen on one clock edge
    typedef struct packed {
        logic             all_lanes_write_n;
        logic             lane_write_enable_n;
        logic [LANES-1:0] lane_select_n;
    } write_pins_t;

    // Next burst index for either order
    function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] first,
                                                      input logic [BURST_W-1:0] cnt,
                                                      input logic linear);
        logic [BURST_W-1:0] step;
        step = cnt + 2'h1;
        burst_next = linear ? (first + step) : (first ^ step);
    endfunction
endpackage

//--- rtl/read_skid.sv
// Two-entry buffer for read words
`timescale 1ns/1ns
module read_skid #(
    parameter int W = 36
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] slot [2];
    logic         rd_ptr;
    logic         wr_ptr;
    logic [1:0]   count;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = slot[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (clk_en) begin
            if (in_valid && in_ready) begin
                slot[wr_ptr] <= in_data;
                wr_ptr       <= ~wr_ptr;
            end
            if (out_valid && out_ready)
                rd_ptr <= ~rd_ptr;
            count <= count + 2'((in_valid && in_ready) ? 1 : 0)
                           - 2'((out_valid && out_ready) ? 1 : 0);
        end
    end
endmodule

//--- rtl/lane_memory.sv
// Word array with per-lane write strobes
`timescale 1ns/1ns
module lane_memory #(
    parameter int AW = 10,
    parameter int LN = 4,
    parameter int LW = 9
) (
    input  wire logic             sys_clk,
    input  wire logic             clk_en,
    input  wire logic [LN-1:0]    lane_we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [LN*LW-1:0] wdata,
    output logic [LN*LW-1:0]      rdata
);
    logic [LN*LW-1:0] mem [2**AW];

    assign rdata = mem[addr];

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            for (int i = 0; i < LN; i++) begin
                if (lane_we[i])
                    mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
            end
        end
    end
endmodule

//--- rtl/sync_burst_sram_port.sv
// Pipelined burst SRAM port: strobes, burst counter, writes, read pipe
`timescale 1ns/1ns
// What this block does
// - Capture address on strobe with chip selected
// - Address strobe loads low bits into counter
// - Both strobes low: processor strobe wins
// - First select high: processor strobe loads nothing but still blocks controller strobe
// - Selected when first, third low, second high
// - Selects sampled only on new address
// - Advance low increments burst counter
// - All-lanes write ignores lane controls
// - Lane write enable writes selected lanes only
// - Lane selects count only with lane enable
// - Output enable low drives, high tri-states
// - First read after deselect stays tri-stated
// - Data and parity registered on clock
// - Read data appears one cycle later
// - Sleep input halts activity, keeps contents
// - Mode strap picks linear or interleaved
// - Two-bit counter wraps within four words
// - Processor-strobe write takes controls next edge
// - Write cycle forces data lines tri-stated
module sync_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int AW = sram_port_pkg::ADDR_W
) (
    input  wire logic                             sys_clk,
    input  wire logic                             rst,
    input  wire logic                             clk_en,
    input  wire logic [AW-1:0]                    addr,
    input  wire sram_port_pkg::ctrl_pins_t        ctrl,
    input  wire sram_port_pkg::write_pins_t       wr,
    input  wire logic                             out_enable_n,
    input  wire logic                             sleep_request,
    input  wire logic                             burst_mode,
    input  wire logic [sram_port_pkg::WORD_W-1:0] data_in,
    output logic [sram_port_pkg::WORD_W-1:0]      data_out,
    output logic [sram_port_pkg::WORD_W-1:0]      data_oe,
    output logic                                  rd_valid,
    input  wire logic                             rd_ready,
    output logic [sram_port_pkg::WORD_W-1:0]      rd_data,
    output logic                                  asleep
);
    import sram_port_pkg::*;

    port_state_t               state;
    logic [AW-1:0]             base_addr;
    logic [BURST_W-1:0]        first_idx;
    logic [BURST_W-1:0]        burst_cnt;
    logic [BURST_W-1:0]        cur_idx;
    logic                      linear;
    logic                      pending_proc;
    logic                      first_read;
    logic [WORD_W-1:0]         data_reg;
    logic [WORD_W-1:0]         read_word;
    logic [WORD_W-1:0]         out_reg;
    logic                      out_live;
    logic                      out_is_write;
    logic [LANES-1:0]          next_lane_we;
    logic [AW-1:0]             mem_addr;
    logic                      selected;
    logic                      proc_load;
    logic                      ctrl_load;
    logic                      load;
    logic                      direct_write;
    logic                      is_write;
    logic                      advance;
    logic                      skid_ready;
    logic                      run;

    assign run      = clk_en && !sleep_request && skid_ready;
    assign selected = !ctrl.select_first_n && ctrl.select_second
                      && !ctrl.select_third_n;
    assign proc_load = !ctrl.proc_addr_strobe_n && !ctrl.select_first_n;
    assign ctrl_load = !ctrl.ctrl_addr_strobe_n && ctrl.proc_addr_strobe_n;
    assign load      = proc_load || ctrl_load;
    assign is_write  = !wr.all_lanes_write_n || !wr.lane_write_enable_n;
    // Write controls and advance ignored on a processor-strobe load edge
    assign advance   = !load && !ctrl.burst_advance_n && state != st_idle
                       && !pending_proc;
    assign cur_idx   = burst_next(first_idx, burst_cnt - 2'h1, linear);
    // Controller-strobe write lands at the address on the pins
    assign direct_write = ctrl_load && selected && is_write;
    assign mem_addr  = direct_write ? addr : {base_addr[AW-1:BURST_W], cur_idx};

    always_comb begin
        next_lane_we = '0;
        if ((state != st_idle && !load) || direct_write) begin
            if (!wr.all_lanes_write_n)
                next_lane_we = '1;
            else if (!wr.lane_write_enable_n)
                next_lane_we = ~wr.lane_select_n;
        end
    end

    // Mode strap sampled on each enabled edge while idle
    always_ff @(posedge sys_clk) begin
        if (rst)
            linear <= 1'b0;
        else if (clk_en && state == st_idle)
            linear <= (burst_mode == MODE_LINEAR);
    end

    // Address capture and burst counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            base_addr <= '0;
            first_idx <= BURST_RST;
            burst_cnt <= BURST_RST;
        end else if (run) begin
            if (load && selected) begin
                base_addr <= addr;
                first_idx <= addr[BURST_W-1:0];
                burst_cnt <= BURST_RST;
            end else if (advance) begin
                burst_cnt <= burst_cnt + 2'h1;
            end
        end
    end

    // Access state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state        <= st_idle;
            pending_proc <= 1'b0;
            first_read   <= 1'b0;
        end else if (clk_en) begin
            if (sleep_request) begin
                state <= st_sleep;
            end else if (run) begin
                pending_proc <= 1'b0;
                case (state)
                    st_sleep: state <= st_idle;
                    default: begin
                        if (load && !selected) begin
                            state <= st_idle;
                        end else if (load) begin
                            first_read   <= (state == st_idle);
                            pending_proc <= proc_load;
                            state <= (!proc_load && is_write) ? st_write : st_read;
                        end else if (state != st_idle) begin
                            first_read <= 1'b0;
                            state <= is_write ? st_write : st_read;
                        end
                    end
                endcase
            end
        end
    end

    // Input data register
    always_ff @(posedge sys_clk) begin
        if (rst)
            data_reg <= '0;
        else if (run)
            data_reg <= data_in;
    end

    lane_memory #(.AW(AW), .LN(LANES), .LW(LANE_W)) u_mem (
        .sys_clk (sys_clk),
        .clk_en  (run),
        .lane_we (next_lane_we),
        .addr    (mem_addr),
        .wdata   (data_in),
        .rdata   (read_word)
    );

    // Output register: word of the previous edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_reg      <= '0;
            out_live     <= 1'b0;
            out_is_write <= 1'b0;
        end else if (run) begin
            out_reg      <= read_word;
            out_live     <= (state == st_read) && !first_read;
            out_is_write <= |next_lane_we;
        end
    end

    assign data_out = out_reg;
    assign data_oe  = {WORD_W{out_live && !out_is_write && !out_enable_n
                              && !sleep_request}};
    assign asleep   = (state == st_sleep);

    read_skid #(.W(WORD_W)) u_skid (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .clk_en    (clk_en && !sleep_request),
        .in_valid  (out_live && !out_is_write),
        .in_ready  (skid_ready),
        .in_data   (out_reg),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    property p_sleep_state;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && sleep_request) |=> asleep;
    endproperty
    a_sleep_state: assert property (p_sleep_state) else $error("sleep not entered");

    property p_no_drive_write;
        @(posedge sys_clk) disable iff (rst)
        out_is_write |-> (data_oe == '0);
    endproperty
    a_no_drive_write: assert property (p_no_drive_write) else $error("drove on write");

    property p_oe_high;
        @(posedge sys_clk) disable iff (rst)
        out_enable_n |-> (data_oe == '0);
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("drove with oe high");

    property p_load_cnt;
        @(posedge sys_clk) disable iff (rst)
        (run && load && selected) |=> (first_idx == $past(addr[1:0]) && burst_cnt == BURST_RST);
    endproperty
    a_load_cnt: assert property (p_load_cnt) else $error("counter not loaded");

    property p_deselect;
        @(posedge sys_clk) disable iff (rst)
        (run && !sleep_request && load && !selected) |=> state == st_idle;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect ignored");

    property p_proc_write_skip;
        @(posedge sys_clk) disable iff (rst)
        (run && proc_load) |-> next_lane_we == '0;
    endproperty
    a_proc_write_skip: assert property (p_proc_write_skip) else $error("early write");

    property p_global;
        @(posedge sys_clk) disable iff (rst)
        (state != st_idle && !load && !wr.all_lanes_write_n) |-> next_lane_we == '1;
    endproperty
    a_global: assert property (p_global) else $error("global write partial");

    property p_no_lane_enable;
        @(posedge sys_clk) disable iff (rst)
        (wr.all_lanes_write_n && wr.lane_write_enable_n) |-> next_lane_we == '0;
    endproperty
    a_no_lane_enable: assert property (p_no_lane_enable) else $error("unqualified lane");

    property p_capture;
        @(posedge sys_clk) disable iff (rst)
        (run && load && selected) |=> base_addr == $past(addr);
    endproperty
    a_capture: assert property (p_capture) else $error("no capture");

    property p_proc_wins;
        @(posedge sys_clk) disable iff (rst)
        (run && state != st_sleep && selected && !ctrl.proc_addr_strobe_n
         && !ctrl.ctrl_addr_strobe_n) |=> pending_proc;
    endproperty
    a_proc_wins: assert property (p_proc_wins) else $error("ctrl strobe won");

    property p_proc_gated;
        @(posedge sys_clk) disable iff (rst)
        (run && !ctrl.proc_addr_strobe_n && ctrl.select_first_n && ctrl.ctrl_addr_strobe_n)
        |=> $stable(base_addr);
    endproperty
    a_proc_gated: assert property (p_proc_gated) else $error("strobe not gated");

    property p_access_held;
        @(posedge sys_clk) disable iff (rst)
        (run && !load && (state == st_read || state == st_write)) |=> state != st_idle;
    endproperty
    a_access_held: assert property (p_access_held) else $error("access dropped");

    property p_advance;
        @(posedge sys_clk) disable iff (rst)
        (run && !load && !ctrl.burst_advance_n && state != st_idle && !pending_proc)
        |=> burst_cnt == $past(burst_cnt) + 2'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("no advance");

    property p_lane_write;
        @(posedge sys_clk) disable iff (rst)
        (state != st_idle && !load && wr.all_lanes_write_n && !wr.lane_write_enable_n)
        |-> next_lane_we == ~wr.lane_select_n;
    endproperty
    a_lane_write: assert property (p_lane_write) else $error("lane mask wrong");

    property p_data_reg;
        @(posedge sys_clk) disable iff (rst)
        run |=> data_reg == $past(data_in);
    endproperty
    a_data_reg: assert property (p_data_reg) else $error("data not held");

    property p_first_masked;
        @(posedge sys_clk) disable iff (rst)
        (run && load && selected && state == st_idle) |=> ##1 (data_oe == '0);
    endproperty
    a_first_masked: assert property (p_first_masked) else $error("first read driven");

    property p_read_pipe;
        @(posedge sys_clk) disable iff (rst)
        (run && state == st_read) |=> data_out == $past(read_word);
    endproperty
    a_read_pipe: assert property (p_read_pipe) else $error("read pipe wrong");

    property p_start_index;
        @(posedge sys_clk) disable iff (rst)
        (run && load && selected) |=> cur_idx == $past(addr[BURST_W-1:0]);
    endproperty
    a_start_index: assert property (p_start_index) else $error("bad first index");

    sequence s_proc_start;
        run && proc_load && selected;
    endsequence

    sequence s_global_now;
        !load && !wr.all_lanes_write_n;
    endsequence

    property p_proc_second;
        @(posedge sys_clk) disable iff (rst)
        s_proc_start ##1 s_global_now |-> next_lane_we == '1;
    endproperty
    a_proc_second: assert property (p_proc_second) else $error("second edge skipped");
endmodule

//--- tb/sram_host_model.sv
// Host side model driving the port's synchronous pins
`timescale 1ns/1ns
module sram_host_model (
    input  wire logic                         sys_clk,
    output logic [sram_port_pkg::ADDR_W-1:0]  addr,
    output sram_port_pkg::ctrl_pins_t         ctrl,
    output sram_port_pkg::write_pins_t        wr,
    output logic [sram_port_pkg::WORD_W-1:0]  data_in
);
    import sram_port_pkg::*;
    initial begin
        addr = '0;
        ctrl = 6'h3d;
        wr = 6'h3f;
        data_in = 36'h0_5a5a_5a5a;
    end
    // One cycle: strobes {proc, ctrl, advance}, selects {first, second, third}
    task automatic step(input logic [2:0] strb, input logic [2:0] sel,
                        input logic [ADDR_W-1:0] a, input logic [5:0] w,
                        input logic [WORD_W-1:0] d);
        @(posedge sys_clk);
        #1;
        ctrl = {strb, sel};
        addr = a;
        wr = w;
        // Released data lines keep changing
        data_in = (&w) ? ~data_in : d;
    endtask
endmodule

//--- tb/sync_burst_sram_port_tb.sv
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ns
module sync_burst_sram_port_tb;
    import sram_port_pkg::*;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] CS = 3'h5;
    localparam logic [2:0] PS = 3'h3;
    localparam logic [2:0] BURST_ADVANCE_N = 3'h6;
    localparam logic [2:0] NONE = 3'h7;
    logic                sys_clk;
    logic                rst;
    logic                sleep_request;
    logic                burst_mode;
    logic                out_enable_n;
    logic                rd_ready;
    logic [ADDR_W-1:0]   addr;
    ctrl_pins_t          ctrl;
    write_pins_t         wr;
    logic [WORD_W-1:0]   data_in;
    logic [WORD_W-1:0]   data_out;
    logic [WORD_W-1:0]   data_oe;
    logic                rd_valid;
    logic [WORD_W-1:0]   rd_data;
    logic                asleep;
    logic [WORD_W-1:0]   mem [0:(1<<ADDR_W)-1];
    logic [WORD_W-1:0]   got_q [$];
    int                  miscompares;
    int                  n_compared;

    sync_burst_sram_port sync_burst_sram_port_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
        .addr(addr), .ctrl(ctrl), .wr(wr), .out_enable_n(out_enable_n),
        .sleep_request(sleep_request), .burst_mode(burst_mode), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .asleep(asleep));
    sram_host_model sram_host_model_i (.sys_clk(sys_clk), .addr(addr), .ctrl(ctrl), .wr(wr),
        .data_in(data_in));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rst === 1'b0 && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            got_q.push_back(rd_data);
        end
    end
    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic desel(input logic [5:0] w);
        sram_host_model_i.step(CS, 3'h0, '0, w, 36'h0_dead_beef);
    endtask
    task automatic lwrite(input logic [ADDR_W-1:0] a, input logic [5:0] w,
                          input logic [WORD_W-1:0] d);
        sram_host_model_i.step(CS, SEL, a, w, d);
        for (int i = 0; i < LANES; i++) begin
            if (!w[5] || (!w[4] && !w[i])) begin
                mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
            end
        end
        desel(6'h15);
        if (!w[5]) check(data_oe, '0);
    endtask
    task automatic rd_burst(input logic [ADDR_W-1:0] a, input int n, input logic stall);
        logic [1:0] idx;
        got_q.delete();
        rd_ready = !stall;
        sram_host_model_i.step(CS, SEL, a, 6'h3f, '0);
        for (int k = 1; k <= n; k++) begin
            sram_host_model_i.step(BURST_ADVANCE_N, 3'h0, a, 6'h3f, '0);
            if (k <= 2) check(data_oe, '0);
            if (k == 3 && !stall) begin
                check(data_oe, '1);
                out_enable_n = 1'b1;
                #1;
                check(data_oe, '0);
                out_enable_n = 1'b0;
            end
        end
        desel(6'h3f);
        if (stall) begin
            repeat (4) @(posedge sys_clk);
            #1;
            check(rd_valid, 1'b1);
            check(36'(got_q.size()), 36'h0);
            rd_ready = 1'b1;
        end
        repeat (6) @(posedge sys_clk);
        #1;
        check(36'(got_q.size()), 36'(n));
        check(rd_valid, 1'b0);
        for (int k = 1; k <= n; k++) begin
            idx = burst_mode ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
            check(got_q[k-1], mem[{a[ADDR_W-1:2], idx}]);
        end
    endtask
    task automatic faults_and_proc_write();
        sram_host_model_i.step(PS, 3'h6, 8, 6'h3f, '0);
        sram_host_model_i.step(NONE, SEL, 8, 6'h15, 36'h0_0bad_0bad);
        desel(6'h15);
        sram_host_model_i.step(3'h1, SEL, 9, 6'h15, 36'h0_0bad_0bad);
        sram_host_model_i.step(NONE, SEL, 9, 6'h3f, '0);
        desel(6'h3f);
        sram_host_model_i.step(PS, SEL, 11, 6'h15, 36'h0_0bad_0bad);
        sram_host_model_i.step(NONE, SEL, 11, 6'h15, 36'h9_8765_4321);
        mem[11] = 36'h9_8765_4321;
        desel(6'h3f);
    endtask
    task automatic sleep_cycle();
        sleep_request = 1'b1;
        for (int t = 0; t < 10 && asleep !== 1'b1; t++) @(posedge sys_clk);
        #1;
        check(asleep, 1'b1);
        sleep_request = 1'b0;
        for (int t = 0; t < 10 && asleep !== 1'b0; t++) @(posedge sys_clk);
        #1;
        check(asleep, 1'b0);
        rd_burst(10, 2, 1'b0);
    endtask
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        sleep_request = 1'b0;
        burst_mode = MODE_LINEAR;
        out_enable_n = 1'b0;
        rd_ready = 1'b1;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check(data_oe, '0);
        check(rd_valid, 1'b0);
        check(asleep, 1'b0);
        for (int k = 0; k < 4; k++) lwrite(10'(8 + k), 6'h15, 36'h1_2345_6700 + 36'(k));
        rd_burst(9, 3, 1'b0);
        burst_mode = 1'b1;
        rd_burst(9, 3, 1'b0);
        burst_mode = MODE_LINEAR;
        lwrite(10, 6'h2a, 36'h0_aaaa_aaaa);
        lwrite(11, 6'h30, 36'h0_cccc_cccc);
        faults_and_proc_write();
        rd_burst(8, 3, 1'b0);
        rd_burst(9, 2, 1'b1);
        sleep_cycle();
        tally_and_finish();
    end
endmodule
